// [rtl/t16_defines.vh]
/*
  Constants of the 16-bit timer core: register select codes, field
  positions, reset values, clock select codes and fixed top values.
  Assumes inclusion by bare name from the timer design files.
*/
`ifndef T16_DEFINES_VH
`define T16_DEFINES_VH

// Register select codes on cpu_addr.
`define T16_A_CNT_L 4'h0
`define T16_A_CNT_H 4'h1
`define T16_A_OCA_L 4'h2
`define T16_A_OCA_H 4'h3
`define T16_A_OCB_L 4'h4
`define T16_A_OCB_H 4'h5
`define T16_A_CAP_L 4'h6
`define T16_A_CAP_H 4'h7
`define T16_A_CTRL_A 4'h8
`define T16_A_CTRL_B 4'h9
`define T16_A_FLAGS 4'ha
`define T16_A_MASK 4'hb

// Control A fields.
`define T16_CA_FOC_A 7
`define T16_CA_FOC_B 6
`define T16_CA_COM_A_HI 5
`define T16_CA_COM_A_LO 4
`define T16_CA_COM_B_HI 3
`define T16_CA_COM_B_LO 2
`define T16_CA_WGM_HI 1
`define T16_CA_WGM_LO 0

// Control B fields.
`define T16_CB_FILT 7
`define T16_CB_EDGE 6
`define T16_CB_SRC 5
`define T16_CB_WGM_HI 4
`define T16_CB_WGM_LO 3
`define T16_CB_CS_HI 2
`define T16_CB_CS_LO 0

// Flag and mask bit positions.
`define T16_F_OVF 0
`define T16_F_CMPB 1
`define T16_F_CMPA 2
`define T16_F_CAP 3

// Reset values.
`define T16_RST_BYTE 8'h00
`define T16_RST_WORD 16'h0000
`define T16_RST_FLAGS 4'h0

// Count limits.
`define T16_BOTTOM 16'h0000
`define T16_MAX 16'hffff
`define T16_TOP8 16'h00ff
`define T16_TOP9 16'h01ff
`define T16_TOP10 16'h03ff

// Clock select codes.
`define T16_CS_STOP 3'h0
`define T16_CS_CLK 3'h1
`define T16_CS_D8 3'h2
`define T16_CS_D64 3'h3
`define T16_CS_D256 3'h4
`define T16_CS_D1024 3'h5
`define T16_CS_EXT_FALL 3'h6
`define T16_CS_EXT_RISE 3'h7

// Noise filter length in samples.
`define T16_FILT_LEN 4

`endif

// [rtl/t16_prescaler.v]
/*
  Free running prescaler giving one-cycle ticks at clk divided by 8, 64,
  256 and 1024. Assumes a single clock and a synchronous reset.
*/
`timescale 1ns/100ps
module t16_prescaler #(
  parameter WIDTH = 10
) (
  input wire clk, // System clock.
  input wire reset, // Synchronous reset, active high.
  output reg [3:0] tick_reg // Ticks /8, /64, /256, /1024.
);
  reg [WIDTH-1:0] count_reg;

  always @(posedge clk) begin
    if (reset) begin
      count_reg <= {WIDTH{1'b0}};
      tick_reg <= 4'h0;
    end else begin
      count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      tick_reg[0] <= &count_reg[2:0];
      tick_reg[1] <= &count_reg[5:0];
      tick_reg[2] <= &count_reg[7:0];
      tick_reg[3] <= &count_reg[9:0];
    end
  end
endmodule // t16_prescaler

// [rtl/t16_capture_filter.v]
/*
  Noise filter for the capture input: the output follows the input only
  after LEN equal samples in a row. Assumes a synchronised input.
*/
`timescale 1ns/100ps
module t16_capture_filter #(
  parameter LEN = 4
) (
  input wire clk, // System clock.
  input wire reset, // Synchronous reset, active high.
  input wire enable, // Filter on when high.
  input wire din, // Synchronised input level.
  output reg dout_reg // Filtered level.
);
  reg [LEN-2:0] hist_reg;

  always @(posedge clk) begin
    if (reset) begin
      hist_reg <= {(LEN-1){1'b0}};
      dout_reg <= 1'b0;
    end else begin
      hist_reg <= {hist_reg[LEN-3:0], din};
      if (!enable) begin
        dout_reg <= din;
      end else if (&{hist_reg, din}) begin
        dout_reg <= 1'b1;
      end else if (~|{hist_reg, din}) begin
        dout_reg <= 1'b0;
      end
    end
  end
endmodule // t16_capture_filter

// [rtl/t16_core.v]
/*
  16-bit timer/counter core with byte access through one shared high-byte
  holding register, compare values double-buffered in PWM modes, capture, flags and
  masks. Assumes an 8-bit CPU on the same clock issuing one-cycle read and
  write strobes; pins and the comparator are asynchronous.
*/
`timescale 1ns/100ps
`include "t16_defines.vh"

// What this block does
// - Counter, compares, capture are 16-bit registers
// - Control registers are plain 8-bit access
// - Each request flagged and individually masked
// - Clock select picks tick source and edge
// - Compares match counter continuously, set flags
// - Match drives waveform on compare pin
// - Capture edge copies counter into capture unless capture is top
// - Optional noise filter on capture input
// - Top from compare A, capture, fixed
// - No PWM on A when A is top
// - Compare A as top is double buffered in PWM modes only
// - Bottom is counter zero
// - Max is counter all ones
// - Top flagged at highest count value
// - One shared high-byte holding register
// - Low write loads holding plus low byte
// - Low read copies high into holding
// - Compare reads bypass the holding register
// - Force bits in A, two mode bits in B
// - Clock select zero stops the counter
// - CPU counter write beats count or clear
// - Capture flag cleared by service or one
// - Prescaled tick divides by 8/64/256/1024
module t16_core (
  input wire clk, // System clock.
  input wire reset, // Synchronous reset, active high.
  input wire [3:0] cpu_addr, // Register select.
  input wire cpu_wr, // Write strobe, one cycle.
  input wire cpu_rd, // Read strobe, one cycle.
  input wire [7:0] cpu_wdata, // Write data.
  output reg [7:0] cpu_rdata, // Read data, valid after the read edge.
  input wire ext_count_pin, // External count input.
  input wire capture_pin, // Capture input.
  input wire comparator_output, // Analog comparator result.
  input wire [3:0] int_ack, // Interrupt serviced, per flag.
  output reg compare_out_pin_a, // Compare output A.
  output reg compare_out_pin_b, // Compare output B.
  output reg [3:0] irq, // Masked requests, per flag.
  output reg at_bottom, // Counter is zero.
  output reg at_max, // Counter is all ones.
  output reg at_top // Counter equals current top.
);
  reg [15:0] timer_count_reg, timer_count_next;
  reg [15:0] cmp_a_buf_reg, cmp_b_buf_reg;
  reg [15:0] compare_value_a, compare_value_b;
  reg [15:0] capture_value;
  reg [7:0] hold_reg;
  reg [7:0] timer_control_a, timer_control_b;
  reg [3:0] timer_flag_reg, timer_mask_reg, flag_next;
  reg dir_up_reg, dir_up_next;
  reg ext_s1, ext_s2, ext_prev;
  reg cap_s1, cap_s2, cmp_s1, cmp_s2, cap_prev;
  reg timer_tick;
  wire [3:0] pre_tick;
  wire cap_filt;

  wire [3:0] waveform_mode_bits = {
    timer_control_b[`T16_CB_WGM_HI:`T16_CB_WGM_LO],
    timer_control_a[`T16_CA_WGM_HI:`T16_CA_WGM_LO]};
  wire [2:0] clock_select_bits =
    timer_control_b[`T16_CB_CS_HI:`T16_CB_CS_LO];
  wire [1:0] com_a = timer_control_a[`T16_CA_COM_A_HI:`T16_CA_COM_A_LO];
  wire [1:0] com_b = timer_control_a[`T16_CA_COM_B_HI:`T16_CA_COM_B_LO];

  wire wr_ctrl_a = cpu_wr && cpu_addr == `T16_A_CTRL_A;
  wire force_compare_a = wr_ctrl_a && cpu_wdata[`T16_CA_FOC_A];
  wire force_compare_b = wr_ctrl_a && cpu_wdata[`T16_CA_FOC_B];
  wire wr_cnt = cpu_wr && cpu_addr == `T16_A_CNT_L;
  wire [15:0] wr_word = {hold_reg, cpu_wdata};

  // Mode class decoders.
  function is_pwm;
    input [3:0] m;
    begin
      is_pwm = !(m == 4'h0 || m == 4'h4 || m == 4'hc || m == 4'hd);
    end
  endfunction

  function is_dual;
    input [3:0] m;
    begin
      is_dual = (m >= 4'h1 && m <= 4'h3) || (m >= 4'h8 && m <= 4'hb);
    end
  endfunction

  function top_from_a;
    input [3:0] m;
    begin
      top_from_a = m == 4'h4 || m == 4'h9 || m == 4'hb || m == 4'hf;
    end
  endfunction

  function top_from_cap;
    input [3:0] m;
    begin
      top_from_cap = m == 4'h8 || m == 4'ha || m == 4'hc || m == 4'he;
    end
  endfunction

  // Next level of a compare output for one channel.
  function wave_next;
    input cur;
    input [1:0] com;
    input match;
    input force_it;
    input pwm;
    input dual;
    input dir_up;
    input wrap;
    begin
      wave_next = cur;
      if (com == 2'h1) begin
        if (match || (force_it && !pwm))
          wave_next = ~cur;
      end else if (com != 2'h0) begin
        if (!pwm) begin
          if (match || force_it)
            wave_next = com[0];
        end else if (dual) begin
          if (match)
            wave_next = dir_up ? com[0] : ~com[0];
        end else if (match) begin
          wave_next = com[0];
        end else if (wrap) begin
          wave_next = ~com[0];
        end
      end
    end
  endfunction

  wire pwm = is_pwm(waveform_mode_bits);
  wire dual = is_dual(waveform_mode_bits);
  wire a_is_top = top_from_a(waveform_mode_bits);
  wire cap_is_top = top_from_cap(waveform_mode_bits);

  // In PWM modes A as top comes from the buffered (active) value.
  reg [15:0] top_value;
  always @* begin
    case (waveform_mode_bits)
      4'h1, 4'h5: top_value = `T16_TOP8;
      4'h2, 4'h6: top_value = `T16_TOP9;
      4'h3, 4'h7: top_value = `T16_TOP10;
      4'h4: top_value = cmp_a_buf_reg;
      4'h9, 4'hb, 4'hf: top_value = compare_value_a;
      4'h8, 4'ha, 4'hc, 4'he: top_value = capture_value;
      default: top_value = `T16_MAX;
    endcase
  end

  wire cnt_zero = timer_count_reg == `T16_BOTTOM;
  wire cnt_max = timer_count_reg == `T16_MAX;
  wire cnt_top = timer_count_reg == top_value;
  wire ev_top = timer_tick && cnt_top;
  wire ev_bottom = timer_tick && cnt_zero;
  wire [15:0] act_a = pwm ? compare_value_a : cmp_a_buf_reg;
  wire [15:0] act_b = pwm ? compare_value_b : cmp_b_buf_reg;
  wire match_a = timer_tick && timer_count_reg == act_a;
  wire match_b = timer_tick && timer_count_reg == act_b;
  wire ev_ovf = pwm ? (dual ? ev_bottom : ev_top) : (timer_tick && cnt_max);
  wire buf_load = !pwm ? 1'b1 :
    ((waveform_mode_bits == 4'h8 || waveform_mode_bits == 4'h9) ?
    ev_bottom : ev_top);
  wire [1:0] com_a_eff = (pwm && a_is_top && com_a[1]) ? 2'h0 : com_a;

  // Tick selection from prescaler, system clock or external edges.
  always @* begin
    case (clock_select_bits)
      `T16_CS_STOP: timer_tick = 1'b0;
      `T16_CS_CLK: timer_tick = 1'b1;
      `T16_CS_D8: timer_tick = pre_tick[0];
      `T16_CS_D64: timer_tick = pre_tick[1];
      `T16_CS_D256: timer_tick = pre_tick[2];
      `T16_CS_D1024: timer_tick = pre_tick[3];
      `T16_CS_EXT_FALL: timer_tick = ext_prev && !ext_s2;
      `T16_CS_EXT_RISE: timer_tick = !ext_prev && ext_s2;
      default: timer_tick = 1'b0;
    endcase
  end

  t16_prescaler #(.WIDTH(10)) u_pre (
    .clk(clk),
    .reset(reset),
    .tick_reg(pre_tick)
  );

  wire cap_src = timer_control_b[`T16_CB_SRC] ? cmp_s2 : cap_s2;

  t16_capture_filter #(.LEN(`T16_FILT_LEN)) u_filt (
    .clk(clk),
    .reset(reset),
    .enable(timer_control_b[`T16_CB_FILT]),
    .din(cap_src),
    .dout_reg(cap_filt)
  );

  wire cap_edge = timer_control_b[`T16_CB_EDGE] ? (cap_filt && !cap_prev) :
    (!cap_filt && cap_prev);
  wire do_capture = cap_edge && !cap_is_top;

  // Counter sequence; a CPU write overrides it.
  always @* begin
    timer_count_next = timer_count_reg;
    dir_up_next = dir_up_reg;
    if (timer_tick) begin
      if (dual) begin
        if (dir_up_reg) begin
          if (timer_count_reg >= top_value) begin
            dir_up_next = 1'b0;
            timer_count_next = timer_count_reg - 16'h0001;
          end else begin
            timer_count_next = timer_count_reg + 16'h0001;
          end
        end else if (cnt_zero) begin
          dir_up_next = 1'b1;
          timer_count_next = timer_count_reg + 16'h0001;
        end else begin
          timer_count_next = timer_count_reg - 16'h0001;
        end
      end else if (cnt_top) begin
        timer_count_next = `T16_BOTTOM;
      end else begin
        timer_count_next = timer_count_reg + 16'h0001;
      end
    end
    if (wr_cnt)
      timer_count_next = wr_word;
  end

  // Flags: hardware set wins over software or service clear.
  always @* begin
    flag_next = timer_flag_reg & ~int_ack;
    if (cpu_wr && cpu_addr == `T16_A_FLAGS)
      flag_next = flag_next & ~cpu_wdata[3:0];
    flag_next[`T16_F_OVF] = flag_next[`T16_F_OVF] | ev_ovf;
    flag_next[`T16_F_CMPB] = flag_next[`T16_F_CMPB] | match_b;
    flag_next[`T16_F_CMPA] = flag_next[`T16_F_CMPA] | match_a;
    flag_next[`T16_F_CAP] = flag_next[`T16_F_CAP] | do_capture;
  end

  always @(posedge clk) begin
    if (reset) begin
      timer_count_reg <= `T16_RST_WORD;
      dir_up_reg <= 1'b1;
      cmp_a_buf_reg <= `T16_RST_WORD;
      cmp_b_buf_reg <= `T16_RST_WORD;
      compare_value_a <= `T16_RST_WORD;
      compare_value_b <= `T16_RST_WORD;
      capture_value <= `T16_RST_WORD;
      hold_reg <= `T16_RST_BYTE;
      timer_control_a <= `T16_RST_BYTE;
      timer_control_b <= `T16_RST_BYTE;
      timer_flag_reg <= `T16_RST_FLAGS;
      timer_mask_reg <= `T16_RST_FLAGS;
      cpu_rdata <= `T16_RST_BYTE;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_prev <= 1'b0;
      cap_s1 <= 1'b0;
      cap_s2 <= 1'b0;
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      cap_prev <= 1'b0;
      compare_out_pin_a <= 1'b0;
      compare_out_pin_b <= 1'b0;
      irq <= 4'h0;
      at_bottom <= 1'b1;
      at_max <= 1'b0;
      at_top <= 1'b0;
    end else begin
      ext_s1 <= ext_count_pin;
      ext_s2 <= ext_s1;
      ext_prev <= ext_s2;
      cap_s1 <= capture_pin;
      cap_s2 <= cap_s1;
      cmp_s1 <= comparator_output;
      cmp_s2 <= cmp_s1;
      cap_prev <= cap_filt;
      timer_count_reg <= timer_count_next;
      dir_up_reg <= dir_up_next;
      timer_flag_reg <= flag_next;
      irq <= flag_next & timer_mask_reg;
      at_bottom <= timer_count_next == `T16_BOTTOM;
      at_max <= timer_count_next == `T16_MAX;
      at_top <= timer_count_next == top_value;
      if (buf_load) begin
        compare_value_a <= cmp_a_buf_reg;
        compare_value_b <= cmp_b_buf_reg;
      end
      if (do_capture)
        capture_value <= timer_count_reg;
      compare_out_pin_a <= wave_next(compare_out_pin_a, com_a_eff, match_a,
        force_compare_a, pwm, dual, dir_up_reg, ev_top);
      compare_out_pin_b <= wave_next(compare_out_pin_b, com_b, match_b,
        force_compare_b, pwm, dual, dir_up_reg, ev_top);
      if (cpu_wr) begin
        case (cpu_addr)
          `T16_A_CNT_H, `T16_A_OCA_H, `T16_A_OCB_H, `T16_A_CAP_H:
            hold_reg <= cpu_wdata;
          `T16_A_OCA_L: cmp_a_buf_reg <= wr_word;
          `T16_A_OCB_L: cmp_b_buf_reg <= wr_word;
          `T16_A_CAP_L: capture_value <= wr_word;
          `T16_A_CTRL_A: timer_control_a <= {2'h0, cpu_wdata[5:0]};
          `T16_A_CTRL_B: timer_control_b <= cpu_wdata;
          `T16_A_MASK: timer_mask_reg <= cpu_wdata[3:0];
          default: ;
        endcase
      end
      if (cpu_rd) begin
        case (cpu_addr)
          `T16_A_CNT_L: begin
            cpu_rdata <= timer_count_reg[7:0];
            hold_reg <= timer_count_reg[15:8];
          end
          `T16_A_CAP_L: begin
            cpu_rdata <= capture_value[7:0];
            hold_reg <= capture_value[15:8];
          end
          `T16_A_CNT_H, `T16_A_CAP_H: cpu_rdata <= hold_reg;
          `T16_A_OCA_L: cpu_rdata <= cmp_a_buf_reg[7:0];
          `T16_A_OCA_H: cpu_rdata <= cmp_a_buf_reg[15:8];
          `T16_A_OCB_L: cpu_rdata <= cmp_b_buf_reg[7:0];
          `T16_A_OCB_H: cpu_rdata <= cmp_b_buf_reg[15:8];
          `T16_A_CTRL_A: cpu_rdata <= timer_control_a;
          `T16_A_CTRL_B: cpu_rdata <= timer_control_b;
          `T16_A_FLAGS: cpu_rdata <= {4'h0, timer_flag_reg};
          `T16_A_MASK: cpu_rdata <= {4'h0, timer_mask_reg};
          default: cpu_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule // t16_core

// [test/t16_cpu_model.sv]
/*
  Model of the 8-bit CPU on the timer's register port.
  Assumes the core samples strobes on the rising clock edge.
*/
`timescale 1ns/100ps
module t16_cpu_model (
  input wire clk, // System clock.
  output reg [3:0] cpu_addr, // Register select.
  output reg cpu_wr, // Write strobe.
  output reg cpu_rd, // Read strobe.
  output reg [7:0] cpu_wdata, // Write data.
  input wire [7:0] cpu_rdata // Read data.
);
  initial begin
    cpu_addr = 4'h0;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_wdata = 8'h00;
  end

  // One access at a time, so no second user can touch the holding
  // register between the two bytes of a pair. Released lines show the
  // inverse of their last value on address and data; the strobes drop to zero.
  task automatic access(input bit wr, input [3:0] a, input [7:0] d,
    output [7:0] q);
    @(negedge clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= wr;
    cpu_rd <= !wr;
    @(negedge clk);
    q = cpu_rdata;
    cpu_wr <= 1'b0;
    cpu_rd <= 1'b0;
    cpu_addr <= ~a;
    cpu_wdata <= ~d;
  endtask
endmodule // t16_cpu_model

// [test/t16_core_checker.sv]
/*
  Port checker for the timer core, bound to t16_core.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`include "t16_defines.vh"
module t16_core_checker (
  input wire clk, // Clock.
  input wire reset, // Reset.
  input wire [3:0] cpu_addr, // Select.
  input wire cpu_wr, // Write.
  input wire cpu_rd, // Read.
  input wire [7:0] cpu_wdata, // Write data.
  input wire [7:0] cpu_rdata, // Read data.
  input wire capture_pin, // Capture in.
  input wire comparator_output, // Comparator in.
  input wire [3:0] int_ack, // Serviced.
  input wire [3:0] irq, // Requests.
  input wire at_bottom, // Zero.
  input wire at_max, // All ones.
  input wire at_top // Top.
);
  reg [3:0] quiet_reg;
  reg last_reg;
  reg [3:0] mask_w_reg;

  // Counts cycles since the XOR of the two capture sources last changed.
  always @(posedge clk) begin
    last_reg <= capture_pin ^ comparator_output;
    if (reset || ((capture_pin ^ comparator_output) != last_reg))
      quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hf)
      quiet_reg <= quiet_reg + 4'h1;
    if (reset)
      mask_w_reg <= 4'h0;
    else if (cpu_wr && cpu_addr == `T16_A_MASK)
      mask_w_reg <= cpu_wdata[3:0];
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_reset_state: assert property (disable iff (1'b0)
    reset |=> at_bottom && !at_max && irq == 4'h0 && cpu_rdata == 8'h00)
    else $error("state after reset wrong");
  a_bottom_max_excl: assert property (!(at_bottom && at_max))
    else $error("bottom and max together");
  a_rdata_hold: assert property (!cpu_rd |=> $stable(cpu_rdata))
    else $error("read data moved without read");
  a_unmapped_zero: assert property (cpu_rd && cpu_addr > `T16_A_MASK
    |=> cpu_rdata == 8'h00) else $error("unmapped read not zero");
  a_force_read_zero: assert property (cpu_rd &&
    cpu_addr == `T16_A_CTRL_A |=> cpu_rdata[7:6] == 2'b00)
    else $error("force bits read nonzero");
  a_mask_gates_irq: assert property (cpu_wr &&
    cpu_addr == `T16_A_MASK |-> ##2 (irq & ~mask_w_reg) == 4'h0)
    else $error("masked request visible");
  a_flag_w1c: assert property (cpu_wr && cpu_addr == `T16_A_FLAGS &&
    cpu_wdata[3] && quiet_reg > 4'hb |-> ##[1:2] !irq[3])
    else $error("capture flag not cleared by write");
  a_ack_clears: assert property (int_ack[3] && quiet_reg > 4'hb
    |-> ##[1:2] !irq[3]) else $error("capture flag not cleared by ack");

  c_overflow: cover property (irq[0]);
  c_capture: cover property (irq[3]);
  c_top: cover property (at_top && !at_max);
endmodule // t16_core_checker

bind t16_core t16_core_checker u_checker (.clk(clk), .reset(reset),
  .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
  .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
  .capture_pin(capture_pin), .comparator_output(comparator_output),
  .int_ack(int_ack), .irq(irq), .at_bottom(at_bottom), .at_max(at_max),
  .at_top(at_top));

// [test/testbench.sv]
/*
  Self-checking bench for the timer core through its byte port.
  Assumes the CPU model and the bound checker are compiled first.
*/
`timescale 1ns/100ps
`include "t16_defines.vh"
module testbench;
  reg clk;
  reg reset;
  reg capture_pin;
  reg [3:0] int_ack;
  reg ext_count_pin;
  reg comparator_output;
  wire compare_out_pin_a;
  wire compare_out_pin_b;
  wire [3:0] cpu_addr;
  wire cpu_wr;
  wire cpu_rd;
  wire [7:0] cpu_wdata;
  wire [7:0] cpu_rdata;
  wire [3:0] irq;
  wire at_bottom;
  wire at_max;
  wire at_top;
  integer n_mismatch;
  integer checks_done;
  reg [7:0] q;

  t16_core u_dut (.clk(clk), .reset(reset), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .ext_count_pin(ext_count_pin),
    .capture_pin(capture_pin), .comparator_output(comparator_output),
    .int_ack(int_ack), .compare_out_pin_a(compare_out_pin_a),
    .compare_out_pin_b(compare_out_pin_b),
    .irq(irq), .at_bottom(at_bottom), .at_max(at_max), .at_top(at_top));
  t16_cpu_model u_cpu (.clk(clk), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata));

  task end_sim;
    if (n_mismatch == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task cmp(input [15:0] got, input [15:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task wr(input [3:0] a, input [7:0] d);
    u_cpu.access(1'b1, a, d, q);
  endtask
  task rdm(input [3:0] a, input [7:0] m, input [7:0] e);
    u_cpu.access(1'b0, a, 8'h00, q);
    cmp(q & m, e);
  endtask
  task wr16(input [3:0] a, input [15:0] v);
    wr(a + 4'h1, v[15:8]);
    wr(a, v[7:0]);
  endtask
  task rd16(input [3:0] a, input [15:0] e);
    rdm(a, 8'hff, e[7:0]);
    rdm(a + 4'h1, 8'hff, e[15:8]);
  endtask
  task wait_irq(input integer b, input integer n);
    integer k;
    k = 0;
    while (irq[b] !== 1'b1 && k < n) begin
      @(negedge clk);
      k = k + 1;
    end
    if (irq[b] !== 1'b1) begin
      n_mismatch = n_mismatch + 1;
      $display("mismatch at %0t: request %0d timed out", $time, b);
      end_sim;
    end
  endtask
  task ack(input [3:0] m);
    @(negedge clk);
    int_ack = m;
    @(negedge clk);
    int_ack = 4'h0;
    tick(1);
  endtask
  task top_chk(input [3:0] md, input [15:0] t);
    wr(`T16_A_CTRL_A, {6'h00, md[1:0]});
    wr(`T16_A_CTRL_B, {3'h0, md[3:2], `T16_CS_STOP});
    wr16(`T16_A_CNT_L, t);
    tick(2);
    cmp(at_top, 1'b1);
    wr16(`T16_A_CNT_L, t - 16'h0001);
    tick(2);
    cmp(at_top, 1'b0);
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch = n_mismatch + 1;
    $display("mismatch at %0t: run limit reached", $time);
    end_sim;
  end

  initial begin
    reset = 1'b1;
    capture_pin = 1'b0;
    ext_count_pin = 1'b0;
    comparator_output = 1'b0;
    int_ack = 4'h0;
    n_mismatch = 0;
    checks_done = 0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    cmp({at_bottom, at_max, irq}, 6'h20);
    rdm(`T16_A_CTRL_B, 8'hff, 8'h00);
    rdm(4'hc, 8'hff, 8'h00);
    wr(`T16_A_CTRL_A, 8'hc0);
    rdm(`T16_A_CTRL_A, 8'hff, 8'h00);
    wr(`T16_A_CNT_H, 8'h01);
    tick(2);
    cmp(at_bottom, 1'b1);
    wr(`T16_A_CNT_L, 8'hff);
    tick(2);
    cmp(at_bottom, 1'b0);
    rd16(`T16_A_CNT_L, 16'h01ff);
    wr(`T16_A_CNT_H, 8'hab);
    rdm(`T16_A_CNT_H, 8'hff, 8'hab);
    rd16(`T16_A_CNT_L, 16'h01ff);
    wr16(`T16_A_OCA_L, 16'h0020);
    wr16(`T16_A_OCB_L, 16'h0030);
    wr(`T16_A_OCA_H, 8'h56);
    rd16(`T16_A_OCA_L, 16'h0020);
    rdm(`T16_A_CNT_H, 8'hff, 8'h56);
    wr16(`T16_A_CNT_L, 16'hffff);
    tick(20);
    cmp({at_max, at_bottom}, 2'b10);
    rd16(`T16_A_CNT_L, 16'hffff);
    wr(`T16_A_MASK, 8'h01);
    wr(`T16_A_CTRL_B, {5'h00, `T16_CS_CLK});
    wait_irq(0, 8);
    wr(`T16_A_CTRL_B, 8'h00);
    rdm(`T16_A_FLAGS, 8'h01, 8'h01);
    wr(`T16_A_MASK, 8'h00);
    tick(1);
    cmp(irq[0], 1'b0);
    wr(`T16_A_FLAGS, 8'h01);
    rdm(`T16_A_FLAGS, 8'h01, 8'h00);
    wr(`T16_A_MASK, 8'h04);
    wr(`T16_A_CTRL_B, {5'h00, `T16_CS_CLK});
    wait_irq(2, 60);
    wr(`T16_A_CTRL_B, 8'h00);
    rdm(`T16_A_FLAGS, 8'h04, 8'h04);
    ack(4'h4);
    cmp(irq[2], 1'b0);
    wr(`T16_A_CTRL_B, 8'h40);
    rdm(`T16_A_CTRL_B, 8'hff, 8'h40);
    wr16(`T16_A_CNT_L, 16'h0abc);
    wr(`T16_A_MASK, 8'h08);
    capture_pin = 1'b1;
    wait_irq(3, 10);
    rd16(`T16_A_CAP_L, 16'h0abc);
    tick(12);
    wr(`T16_A_FLAGS, 8'h08);
    tick(1);
    cmp(irq[3], 1'b0);
    capture_pin = 1'b0;
    wr(`T16_A_CTRL_B, 8'hc0);
    tick(12);
    capture_pin = 1'b1;
    tick(2);
    capture_pin = 1'b0;
    tick(12);
    cmp(irq[3], 1'b0);
    capture_pin = 1'b1;
    wait_irq(3, 20);
    tick(12);
    ack(4'h8);
    cmp(irq[3], 1'b0);
    wr16(`T16_A_CNT_L, 16'h0010);
    wr(`T16_A_MASK, 8'h02);
    wr(`T16_A_CTRL_A, 8'h1c);
    wr(`T16_A_CTRL_B, {5'h00, `T16_CS_CLK});
    wait_irq(1, 60);
    wr(`T16_A_CTRL_B, 8'h00);
    cmp({compare_out_pin_a, compare_out_pin_b}, 2'b11);
    wr(`T16_A_CTRL_A, 8'h9c);
    cmp({compare_out_pin_a, compare_out_pin_b}, 2'b01);
    wr16(`T16_A_CNT_L, 16'h0100);
    wr(`T16_A_CTRL_B, {5'h00, `T16_CS_EXT_RISE});
    repeat (3) begin
      ext_count_pin = 1'b1;
      tick(2);
      ext_count_pin = 1'b0;
      tick(2);
    end
    wr(`T16_A_CTRL_B, 8'h00);
    rd16(`T16_A_CNT_L, 16'h0103);
    wr(`T16_A_MASK, 8'h08);
    wr(`T16_A_CTRL_B, 8'h60);
    comparator_output = 1'b1;
    wait_irq(3, 10);
    rd16(`T16_A_CAP_L, 16'h0103);
    top_chk(4'h1, `T16_TOP8);
    top_chk(4'h2, `T16_TOP9);
    top_chk(4'h3, `T16_TOP10);
    top_chk(4'h4, 16'h0020);
    top_chk(4'hc, 16'h0103);
    end_sim;
  end
endmodule // testbench
